// ==== rtl/rcz_pkg.sv ====
// shared constants and types of the relay control zone logic
package rcz_pkg;
  localparam int N_IN = 8;
  localparam int N_RLY = 8;
  localparam int N_ZONE = 16;
  localparam int ZW = 4;
  localparam int SW = 3;
  localparam int TW = 13;
  localparam logic [ZW-1:0] ZONE_NONE = 4'h0;
  // operation_selector values for input and relay zone links
  localparam logic [SW-1:0] OP_TRIG = 3'h1;
  localparam logic [SW-1:0] OP_RETRIG = 3'h2;
  localparam logic [SW-1:0] OP_ACT = 3'h3;
  localparam logic [SW-1:0] OP_DIS = 3'h4;
  // rest polarity and auto-relock selectors
  localparam logic [SW-1:0] REST_ON = 3'h1;
  localparam logic [SW-1:0] REST_OFF = 3'h2;
  localparam logic [SW-1:0] RELOCK_CLOSE = 3'h3;
  localparam logic [SW-1:0] RELOCK_OPEN = 3'h4;
  localparam logic [SW-1:0] RELOCK_OFF = 3'h5;
  // operating mode selectors
  localparam logic [SW-1:0] MODE_CTRL = 3'h1;
  localparam logic [SW-1:0] MODE_DOOR = 3'h2;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_TIME_S = 1;
  localparam int SEC_CYCLES_DFLT = CLK_HZ * TICK_TIME_S;
  localparam int RELOCK_TIME_MS = 500;
  localparam int RELOCK_CYCLES_DFLT = CLK_HZ / 1000 * RELOCK_TIME_MS;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_DELAY = 2'b01,
    TS_RUN = 2'b11,
    TS_LATCH = 2'b10
  } rcz_tstate_t;
endpackage

// ==== rtl/rcz_evt_if.sv ====
// level and edge bundle from the pin synchroniser to the zone logic
interface rcz_evt_if #(parameter int W = 8);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src(output level, rise, fall);
  modport dst(input level, rise, fall);
endinterface

// ==== rtl/rcz_edge.sv ====
// two-flop synchroniser with single-cycle rise and fall detection
module rcz_edge #(parameter int W = 8) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // asynchronous pins
  input wire logic [W-1:0] pin_in,
  // synchronised level and edges
  rcz_evt_if.src ev
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign ev.level = sync_r;
  assign ev.rise = sync_r & ~prev_r;
  assign ev.fall = ~sync_r & prev_r;
endmodule

// ==== rtl/rcz_relay_timer.sv ====
// per-relay control delay and control timer, with latch mode for zero time
module rcz_relay_timer
  import rcz_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // one-second enable
  input wire logic sec_tick,
  // control
  input wire logic start,
  input wire logic clear,
  input wire logic [TW-1:0] delay_s,
  input wire logic [TW-1:0] time_s,
  // status
  output logic active
);
  rcz_tstate_t st_r;
  logic [TW-1:0] cnt_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= TS_IDLE;
      cnt_r <= '0;
    end else if (clear) begin
      st_r <= TS_IDLE;
    end else begin
      unique case (st_r)
        TS_IDLE: begin
          if (start && delay_s != '0) begin
            st_r <= TS_DELAY;
            cnt_r <= delay_s;
          end else if (start && time_s == '0) begin
            st_r <= TS_LATCH;
          end else if (start) begin
            st_r <= TS_RUN;
            cnt_r <= time_s;
          end
        end
        TS_DELAY: begin
          if (sec_tick && cnt_r <= 13'h0001) begin
            if (time_s == '0) begin
              st_r <= TS_LATCH;
            end else begin
              st_r <= TS_RUN;
              cnt_r <= time_s;
            end
          end else if (sec_tick) begin
            cnt_r <= cnt_r - 13'h0001;
          end
        end
        TS_RUN: begin
          // a new start restarts the full time; the alarm level has no say
          if (start) begin
            cnt_r <= time_s;
          end else if (sec_tick && cnt_r <= 13'h0001) begin
            st_r <= TS_IDLE;
          end else if (sec_tick) begin
            cnt_r <= cnt_r - 13'h0001;
          end
        end
        TS_LATCH: begin
          if (start) begin
            st_r <= TS_IDLE;
          end
        end
      endcase
    end
  end

  assign active = (st_r == TS_RUN) || (st_r == TS_LATCH);
endmodule

// ==== rtl/rcz_top.sv ====
// relay control zone logic: alarm and relay links into zones, relay polarity, relock, reporting
//
// Contract
// - any input links to any zone; zone 0 removes the link.
// - trigger starts zone relay timers on alarm; they run out regardless.
// - retrigger starts zone relay timers only when the alarm restores.
// - actuate energises zone relays while alarm active, releases on restore, no timers.
// - disable holds zone relays off while alarm active; clears on restore.
// - control delays apply to trigger, retrigger and valid codes at door readers; not to actuate.
// - master zones take trigger only.
// - a relay can trigger or retrigger other relays through a zone.
// - rest-energised setting inverts the relay output sense.
// - after reset every relay is off; rest-energised outputs energise on the first clock.
// - relock-on-open clears a door-mode relay half a second after its door opens.
// - relock can act on door close instead, or be off.
// - default relock policy is relock on door open.
// - mode is control relay or door; default door.
// - input trip on non-door relay reports plain alarm, not forced door.
// - valid code at non-door reader does not energise its relay.
// - valid code at non-door reader toggles the report mask of its own input alarm only.
// - zero control time makes consecutive starts toggle the relay.
module rcz_top
  import rcz_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DFLT,
  parameter int RELOCK_CYCLES = RELOCK_CYCLES_DFLT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // field pins
  input wire logic [N_IN-1:0] alarm_in,
  input wire logic [N_RLY-1:0] door_sw_in,
  // reader events, one-cycle pulses on core_clk
  input wire logic [N_RLY-1:0] code_valid,
  // input to zone links
  input wire logic [N_IN-1:0][ZW-1:0] in_zone,
  input wire logic [N_IN-1:0][SW-1:0] in_operation_selector,
  // relay to zone links
  input wire logic [N_RLY-1:0][ZW-1:0] rly_zone,
  input wire logic [N_RLY-1:0][SW-1:0] rly_operation_selector,
  // zone membership and master flags
  input wire logic [N_ZONE-1:0][N_RLY-1:0] zone_members,
  input wire logic [N_ZONE-1:0] zone_master,
  // per-relay setup
  input wire logic [N_RLY-1:0][SW-1:0] rest_sel,
  input wire logic [N_RLY-1:0][SW-1:0] relock_sel,
  input wire logic [N_RLY-1:0][SW-1:0] mode_sel,
  input wire logic [N_RLY-1:0][TW-1:0] ctrl_time_s,
  input wire logic [N_RLY-1:0][TW-1:0] ctrl_delay_s,
  // relay drive and state
  output logic [N_RLY-1:0] relay_out_r,
  output logic [N_RLY-1:0] relay_on_r,
  // reporting
  output logic [N_IN-1:0] alarm_report_r,
  output logic [N_IN-1:0] forced_door_r,
  output logic [N_IN-1:0] alarm_masked_r
);
  localparam int DW = $clog2(SEC_CYCLES + 1);
  localparam int RW = $clog2(RELOCK_CYCLES + 1);
  localparam logic [DW-1:0] SEC_LAST = DW'(SEC_CYCLES - 1);
  localparam logic [RW-1:0] RELOCK_LOAD = RW'(RELOCK_CYCLES);
  localparam logic [RW-1:0] RELOCK_ONE = RW'(1);

  rcz_evt_if #(.W(N_IN)) alarm_ev ();
  rcz_evt_if #(.W(N_RLY)) door_ev ();

  rcz_edge #(.W(N_IN)) u_alarm_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(alarm_in),
    .ev(alarm_ev.src)
  );

  rcz_edge #(.W(N_RLY)) u_door_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(door_sw_in),
    .ev(door_ev.src)
  );

  // one-second enable for the relay timers
  logic [DW-1:0] sec_cnt_r;
  logic sec_tick_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_r <= '0;
      sec_tick_r <= 1'b0;
    end else if (sec_cnt_r == SEC_LAST) begin
      sec_cnt_r <= '0;
      sec_tick_r <= 1'b1;
    end else begin
      sec_cnt_r <= sec_cnt_r + DW'(1);
      sec_tick_r <= 1'b0;
    end
  end

  // previous relay state for relay-driven zone edges
  logic [N_RLY-1:0] relay_prev_r;
  logic [N_RLY-1:0] rly_rise;
  logic [N_RLY-1:0] rly_fall;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_prev_r <= '0;
    end else begin
      relay_prev_r <= relay_on_r;
    end
  end

  assign rly_rise = relay_on_r & ~relay_prev_r;
  assign rly_fall = ~relay_on_r & relay_prev_r;

  // zone-level events and holds
  logic [N_ZONE-1:0] zone_start;
  logic [N_ZONE-1:0] zone_act;
  logic [N_ZONE-1:0] zone_dis;

  always_comb begin
    zone_start = '0;
    zone_act = '0;
    zone_dis = '0;
    for (int i = 0; i < N_IN; i++) begin
      if (in_zone[i] != ZONE_NONE) begin
        if (in_operation_selector[i] == OP_TRIG && alarm_ev.rise[i]) begin
          zone_start[in_zone[i]] = 1'b1;
        end
        // master zones only ever take the trigger link
        if (!zone_master[in_zone[i]]) begin
          if (in_operation_selector[i] == OP_RETRIG && alarm_ev.fall[i]) begin
            zone_start[in_zone[i]] = 1'b1;
          end
          if (in_operation_selector[i] == OP_ACT && alarm_ev.level[i]) begin
            zone_act[in_zone[i]] = 1'b1;
          end
          if (in_operation_selector[i] == OP_DIS && alarm_ev.level[i]) begin
            zone_dis[in_zone[i]] = 1'b1;
          end
        end
      end
    end
    for (int r = 0; r < N_RLY; r++) begin
      if (rly_zone[r] != ZONE_NONE) begin
        if (rly_operation_selector[r] == OP_TRIG && rly_rise[r]) begin
          zone_start[rly_zone[r]] = 1'b1;
        end
        if (rly_operation_selector[r] == OP_RETRIG && rly_fall[r] && !zone_master[rly_zone[r]]) begin
          zone_start[rly_zone[r]] = 1'b1;
        end
      end
    end
  end

  // fan zone events out to their member relays
  logic [N_RLY-1:0] zone_rly_start;
  logic [N_RLY-1:0] rly_act;
  logic [N_RLY-1:0] rly_dis;

  always_comb begin
    zone_rly_start = '0;
    rly_act = '0;
    rly_dis = '0;
    for (int z = 1; z < N_ZONE; z++) begin
      zone_rly_start = zone_rly_start | ({N_RLY{zone_start[z]}} & zone_members[z]);
      rly_act = rly_act | ({N_RLY{zone_act[z]}} & zone_members[z]);
      rly_dis = rly_dis | ({N_RLY{zone_dis[z]}} & zone_members[z]);
    end
  end

  // per-relay mode decode
  logic [N_RLY-1:0] door_mode;
  logic [N_RLY-1:0] rest_energised;
  logic [N_RLY-1:0] relock_close;
  logic [N_RLY-1:0] relock_open;

  always_comb begin
    for (int r = 0; r < N_RLY; r++) begin
      // any code other than control relay counts as door
      door_mode[r] = (mode_sel[r] != MODE_CTRL);
      rest_energised[r] = (rest_sel[r] == REST_ON);
      relock_close[r] = (relock_sel[r] == RELOCK_CLOSE);
      // unset or unknown codes fall back to relock on opening
      relock_open[r] = (relock_sel[r] != RELOCK_CLOSE) && (relock_sel[r] != RELOCK_OFF);
    end
  end

  logic [N_RLY-1:0] tmr_active;
  logic [N_RLY-1:0] relock_fire_r;
  logic [N_RLY-1:0] relay_on_nxt;

  genvar g;
  generate
    for (g = 0; g < N_RLY; g++) begin : g_rly
      logic rly_start;
      logic relock_arm;
      logic [RW-1:0] relock_cnt_r;

      // codes at a non-door reader never start the relay
      assign rly_start = (zone_rly_start[g] || (code_valid[g] && door_mode[g])) && !rly_dis[g];

      rcz_relay_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sec_tick(sec_tick_r),
        .start(rly_start),
        .clear(relock_fire_r[g]),
        .delay_s(ctrl_delay_s[g]),
        .time_s(ctrl_time_s[g]),
        .active(tmr_active[g])
      );

      assign relock_arm = relay_on_r[g] && door_mode[g] &&
                          ((relock_open[g] && door_ev.rise[g]) || (relock_close[g] && door_ev.fall[g]));

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          relock_cnt_r <= '0;
          relock_fire_r[g] <= 1'b0;
        end else if (relock_arm) begin
          relock_cnt_r <= RELOCK_LOAD;
          relock_fire_r[g] <= 1'b0;
        end else if (relock_cnt_r == RELOCK_ONE) begin
          relock_cnt_r <= '0;
          relock_fire_r[g] <= 1'b1;
        end else if (relock_cnt_r != '0) begin
          relock_cnt_r <= relock_cnt_r - RELOCK_ONE;
          relock_fire_r[g] <= 1'b0;
        end else begin
          relock_fire_r[g] <= 1'b0;
        end
      end

      // actuate bypasses the timers; disable overrides everything while held
      assign relay_on_nxt[g] = (rly_act[g] || tmr_active[g]) && !rly_dis[g];
    end
  endgenerate

  // relay drive: reset leaves every coil de-energised
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_on_r <= '0;
      relay_out_r <= '0;
    end else begin
      relay_on_r <= relay_on_nxt;
      relay_out_r <= relay_on_nxt ^ rest_energised;
    end
  end

  // per-reader mask of its own input; each valid code at a control relay reader toggles it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_masked_r <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (code_valid[i] && !door_mode[i]) begin
          alarm_masked_r[i] <= ~alarm_masked_r[i];
        end
      end
    end
  end

  // trip reporting: forced door on door inputs, plain alarm otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_report_r <= '0;
      forced_door_r <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        forced_door_r[i] <= alarm_ev.rise[i] && !alarm_masked_r[i] && door_mode[i];
        alarm_report_r[i] <= alarm_ev.rise[i] && !alarm_masked_r[i] && !door_mode[i];
      end
    end
  end
endmodule

// ==== test/rcz_top_checker.sv ====
// assertion checker for the relay control zone ports
module rcz_top_checker
  import rcz_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched inputs
  input wire logic [N_IN-1:0] alarm_in,
  input wire logic [N_RLY-1:0] code_valid,
  input wire logic [N_RLY-1:0][SW-1:0] rest_sel,
  input wire logic [N_RLY-1:0][SW-1:0] mode_sel,
  // watched outputs
  input wire logic [N_RLY-1:0] relay_out_r,
  input wire logic [N_RLY-1:0] relay_on_r,
  input wire logic [N_IN-1:0] alarm_report_r,
  input wire logic [N_IN-1:0] forced_door_r,
  input wire logic [N_IN-1:0] alarm_masked_r
);
  logic [N_RLY-1:0] rest_on;
  logic [N_RLY-1:0] ctrl_m;
  always_comb begin
    for (int r = 0; r < N_RLY; r++) begin
      rest_on[r] = rest_sel[r] == REST_ON;
      ctrl_m[r] = mode_sel[r] == MODE_CTRL;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_pol;
    $past(rst_n) |-> relay_out_r == (relay_on_r ^ $past(rest_on));
  endproperty
  a_pol: assert property (p_pol) else $error("coil drive polarity wrong");
  property p_rst;
    !$past(rst_n) |-> relay_on_r == '0 && (alarm_report_r | forced_door_r) == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("output active right after reset");
  property p_rep;
    (alarm_report_r & ~$past(ctrl_m)) == '0;
  endproperty
  a_rep: assert property (p_rep) else $error("plain alarm on a door input");
  property p_frc;
    (forced_door_r & $past(ctrl_m)) == '0;
  endproperty
  a_frc: assert property (p_frc) else $error("forced door on a control input");
  property p_one;
    ((alarm_report_r | forced_door_r) & $past(alarm_report_r | forced_door_r)) == '0;
  endproperty
  a_one: assert property (p_one) else $error("report longer than one cycle");
  property p_cause;
    ((alarm_report_r | forced_door_r) & ~($past(alarm_in, 2) | $past(alarm_in, 3) | $past(alarm_in, 4))) == '0;
  endproperty
  a_cause: assert property (p_cause) else $error("report without alarm");
  property p_mask;
    $past(rst_n) |-> (alarm_masked_r ^ $past(alarm_masked_r)) == $past(code_valid & ctrl_m);
  endproperty
  a_mask: assert property (p_mask) else $error("mask change without own reader code");
  property p_mrep;
    (alarm_report_r & $past(alarm_masked_r)) == '0;
  endproperty
  a_mrep: assert property (p_mrep) else $error("masked input reported");
  c_frc: cover property (|forced_door_r);
  c_rep: cover property (|alarm_report_r);
  c_mask: cover property (|alarm_masked_r);
endmodule

bind rcz_top rcz_top_checker u_chk (.core_clk, .rst_n, .alarm_in, .code_valid, .rest_sel, .mode_sel,
  .relay_out_r, .relay_on_r, .alarm_report_r, .forced_door_r, .alarm_masked_r);

// ==== test/rcz_field.sv ====
// field side model: alarm contacts and door switches
module rcz_field
  import rcz_pkg::*;
(
  // clock
  input wire logic core_clk,
  // contacts
  output logic [N_IN-1:0] alarm_in,
  output logic [N_RLY-1:0] door_sw_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    alarm_in = '0;
    door_sw_in = '0;
  end
  // contacts move away from the sampling edge
  task automatic set_alarm(input int i, input logic v);
    @(negedge core_clk);
    alarm_in[i] = v;
  endtask
  task automatic set_door(input int i, input logic v);
    @(negedge core_clk);
    door_sw_in[i] = v;
  endtask
endmodule

// ==== test/test_rcz_top.sv ====
// self-checking bench for the relay control zone logic
module test_rcz_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcz_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [N_IN-1:0] alarm_in;
  logic [N_RLY-1:0] door_sw_in;
  logic [N_RLY-1:0] code_valid = '0;
  logic [N_IN-1:0][ZW-1:0] in_zone = 32'h0004_1321;
  logic [N_IN-1:0][SW-1:0] in_operation_selector = '0;
  logic [N_RLY-1:0][ZW-1:0] rly_zone = '0;
  logic [N_RLY-1:0][SW-1:0] rly_operation_selector = '0;
  logic [N_ZONE-1:0][N_RLY-1:0] zone_members = '0;
  logic [N_ZONE-1:0] zone_master = 16'h0010;
  logic [N_RLY-1:0][SW-1:0] rest_sel = '0;
  logic [N_RLY-1:0][SW-1:0] relock_sel = '0;
  logic [N_RLY-1:0][SW-1:0] mode_sel = '0;
  logic [N_RLY-1:0][TW-1:0] ctrl_time_s = '0;
  logic [N_RLY-1:0][TW-1:0] ctrl_delay_s = '0;
  logic [N_RLY-1:0] relay_out_r;
  logic [N_RLY-1:0] relay_on_r;
  logic [N_IN-1:0] alarm_report_r;
  logic [N_IN-1:0] forced_door_r;
  logic [N_IN-1:0] alarm_masked_r;
  logic [7:0] exp_on = 8'h00;
  logic [7:0] rv = 8'h00;
  logic [7:0] rep_seen = 8'h00;
  logic [7:0] frc_seen = 8'h00;
  logic clr = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [SW-1:0] OPS [8] = '{OP_ACT, OP_TRIG, OP_RETRIG, OP_DIS, OP_ACT, OP_TRIG, 3'h0, 3'h0};

  always #10 core_clk = ~core_clk;

  rcz_field u_rcz_field (.core_clk, .alarm_in, .door_sw_in);
  rcz_top #(.SEC_CYCLES(10), .RELOCK_CYCLES(5)) u_rcz_top (.core_clk, .rst_n, .alarm_in, .door_sw_in,
    .code_valid, .in_zone, .in_operation_selector, .rly_zone, .rly_operation_selector, .zone_members,
    .zone_master, .rest_sel, .relock_sel, .mode_sel, .ctrl_time_s, .ctrl_delay_s, .relay_out_r,
    .relay_on_r, .alarm_report_r, .forced_door_r, .alarm_masked_r);

  // one-cycle report pulses are caught here so checks need not hit the exact edge
  always @(posedge core_clk) begin
    rep_seen <= clr ? 8'h00 : rep_seen | alarm_report_r;
    frc_seen <= clr ? 8'h00 : frc_seen | forced_door_r;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp();
    chk(relay_on_r, exp_on);
    chk(relay_out_r, exp_on ^ rv);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(input int r);
    @(negedge core_clk);
    code_valid[r] = 1'b1;
    @(negedge core_clk);
    code_valid[r] = 1'b0;
  endtask
  task automatic clrs();
    @(negedge core_clk);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h9f14));
    rv = 8'($urandom());
    for (int r = 0; r < 8; r++) begin
      rest_sel[r] = rv[r] ? REST_ON : REST_OFF;
      in_operation_selector[r] = OPS[r];
      ctrl_time_s[r] = 13'h0003;
    end
    ctrl_time_s[7] = 13'h0000;
    ctrl_delay_s[0] = 13'($urandom_range(1, 3));
    zone_members[0] = 8'hff;
    zone_members[1] = 8'h01;
    zone_members[2] = 8'h04;
    zone_members[3] = 8'h08;
    zone_members[4] = 8'h10;
    zone_members[5] = 8'h20;
    rly_zone[2] = 4'h5;
    rly_operation_selector[2] = OP_TRIG;
    mode_sel[6] = MODE_CTRL;
    wt(5);
    rst_n = 1'b1;
    wt(3);
    cmp();
    u_rcz_field.set_alarm(0, 1'b1);
    wt(6);
    exp_on = 8'h01;
    cmp();
    chk(frc_seen, 8'h01);
    u_rcz_field.set_alarm(3, 1'b1);
    wt(6);
    exp_on = 8'h00;
    cmp();
    u_rcz_field.set_alarm(3, 1'b0);
    wt(6);
    exp_on = 8'h01;
    cmp();
    u_rcz_field.set_alarm(0, 1'b0);
    wt(6);
    exp_on = 8'h00;
    cmp();
    u_rcz_field.set_alarm(4, 1'b1);
    u_rcz_field.set_alarm(5, 1'b1);
    wt(20);
    cmp();
    u_rcz_field.set_alarm(1, 1'b1);
    wt(10);
    exp_on = 8'h24;
    cmp();
    wt(50);
    exp_on = 8'h00;
    cmp();
    u_rcz_field.set_alarm(1, 1'b0);
    u_rcz_field.set_alarm(2, 1'b1);
    wt(10);
    cmp();
    u_rcz_field.set_alarm(2, 1'b0);
    wt(8);
    exp_on = 8'h08;
    cmp();
    wt(40);
    exp_on = 8'h00;
    // relay 2 now retriggers zone 5: relay 5 waits for relay 2 to time out
    rly_operation_selector[2] = OP_RETRIG;
    u_rcz_field.set_alarm(1, 1'b1);
    wt(10);
    exp_on = 8'h04;
    cmp();
    wt(30);
    exp_on = 8'h20;
    cmp();
    wt(40);
    exp_on = 8'h00;
    cmp();
    clrs();
    u_rcz_field.set_alarm(6, 1'b1);
    wt(6);
    chk(rep_seen, 8'h40);
    chk(frc_seen, 8'h00);
    pulse(6);
    wt(2);
    chk(alarm_masked_r, 8'h40);
    u_rcz_field.set_alarm(6, 1'b0);
    clrs();
    u_rcz_field.set_alarm(6, 1'b1);
    wt(6);
    chk(rep_seen, 8'h00);
    cmp();
    pulse(7);
    wt(26);
    exp_on = 8'h80;
    cmp();
    u_rcz_field.set_door(7, 1'b1);
    wt(20);
    exp_on = 8'h00;
    cmp();
    u_rcz_field.set_door(7, 1'b0);
    pulse(7);
    wt(6);
    exp_on = 8'h80;
    cmp();
    pulse(7);
    wt(6);
    exp_on = 8'h00;
    cmp();
    relock_sel[7] = RELOCK_OFF;
    pulse(7);
    u_rcz_field.set_door(7, 1'b1);
    wt(20);
    exp_on = 8'h80;
    cmp();
    // door is still open; closing it must relock under the close policy
    relock_sel[7] = RELOCK_CLOSE;
    u_rcz_field.set_door(7, 1'b0);
    wt(20);
    exp_on = 8'h00;
    cmp();
    stop_test();
  end
endmodule
